// *** core/ogm_defs.svh ***
// Behaviour
// [RULE1] Words whose three leading bits are 111 are operate-class instructions.
// [RULE2] Operate word with bit 3 zero is group 1, bit 11 ignored.
// [RULE3] Bit 3 one and bit 11 zero is group 2, sent to skip logic.
// [RULE4] Bits 3 and 11 both one is group 3, accumulator and multiplier-quotient work.
// [RULE5] Every set function bit in a word executes; combined code is OR.
// [RULE6] Group 1 functions run in phase order one, two, three, four.
// [RULE7] Same-phase functions act together on values from before that phase.
// [RULE8] Phase 1 clears, phase 2 inverts, phase 3 increments, phase 4 rotates.
// [RULE9] Bit 4 clears all twelve accumulator bits; alone takes 10 states.
// [RULE10] Bit 5 clears the carry; alone takes 10 states.
// [RULE11] Bit 6 inverts every accumulator bit; alone takes 10 states.
// [RULE12] Bit 7 inverts the carry; alone takes 10 states.
// [RULE13] Bit 11 increments accumulator; carry out of top inverts carry.
// [RULE14] Bits 8-10 select swap or rotates; each such word takes 15 states.
// [RULE15] Half swap exchanges accumulator halves, carry unchanged.
// [RULE16] Rotate left one: bit 0 into carry, old carry into bit 11.
// [RULE17] Rotate left two: bit 1 into carry, old carry into bit 10.
// [RULE18] Rotate right one: bit 11 into carry, old carry into bit 0.
// [RULE19] Rotate right two: bit 10 into carry, old carry into bit 1.
// [RULE20] Group 1 word with no function bits takes 10 states, no change.
// [RULE21] Words are twelve bits, bit 0 most significant, bit 11 least.
// [RULE22] Selector codes 110 and 111 act as no rotate and are flagged.
`ifndef OGM_DEFS_SVH
`define OGM_DEFS_SVH

// Architectural bit n (0 = MSB) is vector bit 11-n
`define OGM_OPC_HI       11
`define OGM_OPC_LO       9
`define OGM_OPC_OPERATE  3'h7
`define OGM_GRP_BIT      8
`define OGM_TAIL_BIT     0
`define OGM_CLR_ACC_BIT  7
`define OGM_CLR_CRY_BIT  6
`define OGM_INV_ACC_BIT  5
`define OGM_INV_CRY_BIT  4
`define OGM_ROT_HI       3
`define OGM_ROT_LO       1
`define OGM_INC_BIT      0

// State times per instruction kind
`define OGM_STATES_SHORT 5'h0A
`define OGM_STATES_LONG  5'h0F

`define OGM_ACC_RESET    12'h000
`define OGM_CRY_RESET    1'b0

`endif

// *** core/ogm_pkg.sv ***
package ogm_pkg;

  // Rotate selector values, bits 8..10 read as a 3-bit number
  typedef enum logic [2:0] {
    OGM_ROT_NONE  = 3'h0,
    OGM_ROT_SWAP  = 3'h1,
    OGM_ROT_LEFT1 = 3'h2,
    OGM_ROT_LEFT2 = 3'h3,
    OGM_ROT_RGT1  = 3'h4,
    OGM_ROT_RGT2  = 3'h5,
    OGM_ROT_BAD6  = 3'h6,
    OGM_ROT_BAD7  = 3'h7
  } ogm_rot_e;

  // Instruction classes seen by the decoder
  typedef enum logic [1:0] {
    OGM_CLS_OTHER,
    OGM_CLS_GRP1,
    OGM_CLS_GRP2,
    OGM_CLS_GRP3
  } ogm_cls_e;

endpackage

// *** core/ogm_classify.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ogm_defs.svh"

module ogm_classify
  import ogm_pkg::*;
(
  input  wire logic [11:0] instr,
  output ogm_cls_e         cls
);

  // Opcode, group select and tail bit decide the class
  always_comb begin
    if (instr[`OGM_OPC_HI:`OGM_OPC_LO] != `OGM_OPC_OPERATE) begin // see [RULE1]
      cls = OGM_CLS_OTHER;
    end else if (!instr[`OGM_GRP_BIT]) begin
      cls = OGM_CLS_GRP1;                                      // see [RULE2]
    end else if (!instr[`OGM_TAIL_BIT]) begin
      cls = OGM_CLS_GRP2;                                      // see [RULE3]
    end else begin
      cls = OGM_CLS_GRP3;                                      // see [RULE4]
    end
  end

endmodule
`default_nettype wire

// *** core/ogm_rotator.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ogm_defs.svh"

module ogm_rotator
  import ogm_pkg::*;
(
  input  wire logic [11:0] acc_in,
  input  wire logic        cry_in,
  input  wire logic [2:0]  sel,
  output logic      [11:0] acc_out,
  output logic             cry_out,
  output logic             bad_sel
);

  // Vector bit 0 is the least significant (architectural bit 11)
  logic [12:0] link_acc;
  assign link_acc = {cry_in, acc_in};

  // Phase 4 shifter over the 13-bit carry-plus-accumulator
  always_comb begin
    acc_out = acc_in;
    cry_out = cry_in;
    bad_sel = 1'b0;
    case (ogm_rot_e'(sel))
      OGM_ROT_NONE: begin
      end
      OGM_ROT_SWAP: begin
        acc_out = {acc_in[5:0], acc_in[11:6]};         // see [RULE15]
      end
      OGM_ROT_LEFT1: begin
        {cry_out, acc_out} = {link_acc[11:0], link_acc[12]};   // see [RULE16]
      end
      OGM_ROT_LEFT2: begin
        {cry_out, acc_out} = {link_acc[10:0], link_acc[12:11]}; // see [RULE17]
      end
      OGM_ROT_RGT1: begin
        {cry_out, acc_out} = {link_acc[0], link_acc[12:1]};    // see [RULE18]
      end
      OGM_ROT_RGT2: begin
        {cry_out, acc_out} = {link_acc[1:0], link_acc[12:2]};  // see [RULE19]
      end
      default: begin
        bad_sel = 1'b1;                   // No rotate; see [RULE22]
      end
    endcase
  end

endmodule
`default_nettype wire

// *** core/ogm_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ogm_defs.svh"

// Operate-class decoder and group 1 executor, one phase per clock
module ogm_unit
  import ogm_pkg::*;
#(
  parameter int WIDTH = 12
)
(
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             instr_valid,
  input  wire logic [WIDTH-1:0] instr,
  output logic                  busy_q,
  output logic                  done_q,
  output logic      [4:0]       states_q,
  output logic                  grp2_valid_q,
  output logic                  grp3_valid_q,
  output logic      [WIDTH-1:0] route_word_q,
  output logic                  bad_rot_q,
  output logic      [WIDTH-1:0] accumulator_reg_q,
  output logic                  carry_q
);

  typedef enum {
    ST_IDLE,
    ST_PH1,
    ST_PH2,
    ST_PH3,
    ST_PH4
  } ogm_st_e;

  ogm_st_e          st_q;
  logic [WIDTH-1:0] word_q;
  ogm_cls_e         cls;
  logic [WIDTH-1:0] rot_acc;
  logic             rot_cry;
  logic             rot_bad;
  logic             start;
  logic [WIDTH:0]   inc_sum;

  // Function bits of the held word, names per microinstruction
  logic clear_acc_fn;
  logic clear_carry_fn;
  logic invert_acc_fn;
  logic invert_carry_fn;
  logic increment_acc_fn;
  logic [2:0] rot_sel;
  logic idle_operate_fn;

  assign clear_acc_fn     = word_q[`OGM_CLR_ACC_BIT];         // see [RULE9]
  assign clear_carry_fn   = word_q[`OGM_CLR_CRY_BIT];         // see [RULE10]
  assign invert_acc_fn    = word_q[`OGM_INV_ACC_BIT];         // see [RULE11]
  assign invert_carry_fn  = word_q[`OGM_INV_CRY_BIT];         // see [RULE12]
  assign increment_acc_fn = word_q[`OGM_INC_BIT];             // see [RULE13]
  assign rot_sel          = word_q[`OGM_ROT_HI:`OGM_ROT_LO];  // see [RULE14]
  // No bits in 4..11 set means pure delay
  assign idle_operate_fn  = (word_q[7:0] == 8'h00);           // see [RULE20]

  // Architectural bit 0 is vector bit 11, the MSB; see [RULE21]
  ogm_classify u_cls (
    .instr (instr),
    .cls   (cls)
  );

  ogm_rotator u_rot (
    .acc_in  (accumulator_reg_q),
    .cry_in  (carry_q),
    .sel     (rot_sel),
    .acc_out (rot_acc),
    .cry_out (rot_cry),
    .bad_sel (rot_bad)
  );

  // Only group 1 is executed here; others are only routed
  assign start   = instr_valid && (st_q == ST_IDLE) && (cls == OGM_CLS_GRP1);
  assign inc_sum = {1'b0, accumulator_reg_q} + {{WIDTH{1'b0}}, 1'b1};

  // Phase sequencer, walks every phase in ascending order
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            st_q <= ST_PH1;
          end
        end
        ST_PH1:  st_q <= ST_PH2;                              // see [RULE6]
        ST_PH2:  st_q <= ST_PH3;
        ST_PH3:  st_q <= ST_PH4;
        ST_PH4:  st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Latch the word so the caller may change instr after the start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      word_q <= '0;
    end else if (start) begin
      word_q <= instr;
    end
  end

  // Accumulator: each phase reads only the prior phase result
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      accumulator_reg_q <= `OGM_ACC_RESET;
    end else begin
      case (st_q)
        ST_PH1: begin
          if (clear_acc_fn) begin                             // see [RULE8]
            accumulator_reg_q <= '0;                          // see [RULE9]
          end
        end
        ST_PH2: begin
          if (invert_acc_fn) begin
            accumulator_reg_q <= ~accumulator_reg_q;          // see [RULE11]
          end
        end
        ST_PH3: begin
          if (increment_acc_fn) begin
            accumulator_reg_q <= inc_sum[WIDTH-1:0];          // see [RULE13]
          end
        end
        ST_PH4: begin
          accumulator_reg_q <= rot_acc;                       // see [RULE14]
        end
        default: begin
        end
      endcase
    end
  end

  // Carry: same-phase functions share pre-phase values
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      carry_q <= `OGM_CRY_RESET;
    end else begin
      case (st_q)
        ST_PH1: begin
          if (clear_carry_fn) begin
            carry_q <= 1'b0;                                  // see [RULE10]
          end
        end
        ST_PH2: begin
          if (invert_carry_fn) begin                          // see [RULE7]
            carry_q <= ~carry_q;                              // see [RULE12]
          end
        end
        ST_PH3: begin
          if (increment_acc_fn && inc_sum[WIDTH]) begin
            carry_q <= ~carry_q;                              // see [RULE13]
          end
        end
        ST_PH4: begin
          carry_q <= rot_cry;                                 // see [RULE16]
        end
        default: begin
        end
      endcase
    end
  end

  // Status: busy, completion pulse, state-time cost, bad selector
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      states_q  <= 5'h00;
      bad_rot_q <= 1'b0;
    end else begin
      done_q <= (st_q == ST_PH4);
      if (start) begin
        busy_q <= 1'b1;
      end else if (st_q == ST_PH4) begin
        busy_q <= 1'b0;
      end
      if (st_q == ST_PH4) begin
        // Every set bit ran; cost depends on phase 4 use (see [RULE5])
        if (rot_sel != 3'h0 && !rot_bad) begin
          states_q <= `OGM_STATES_LONG;                       // see [RULE14]
        end else if (idle_operate_fn) begin
          states_q <= `OGM_STATES_SHORT;                      // see [RULE20]
        end else begin
          states_q <= `OGM_STATES_SHORT;
        end
        bad_rot_q <= rot_bad;                                 // see [RULE22]
      end
    end
  end

  // Groups 2 and 3 are handed on for one cycle with the word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      grp2_valid_q <= 1'b0;
      grp3_valid_q <= 1'b0;
      route_word_q <= '0;
    end else begin
      grp2_valid_q <= instr_valid && (st_q == ST_IDLE)
                      && (cls == OGM_CLS_GRP2);               // see [RULE3]
      grp3_valid_q <= instr_valid && (st_q == ST_IDLE)
                      && (cls == OGM_CLS_GRP3);               // see [RULE4]
      if (instr_valid && st_q == ST_IDLE) begin
        route_word_q <= instr;
      end
    end
  end

endmodule
`default_nettype wire

// *** bench/ogm_fetch_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Fetch side: offers one word and holds it until the unit is idle
module ogm_fetch_model
  import ogm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        send,
  input  wire logic [11:0] word,
  input  wire logic        busy_q,
  output var  logic        instr_valid,
  output var  logic [11:0] instr
);
  // Released bus shows the inverse, so a stale word never looks valid
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      instr_valid <= 1'b0;
      instr       <= 12'hFFF;
    end else if (instr_valid && !busy_q) begin
      instr_valid <= 1'b0;
      instr       <= ~instr;
    end else if (send) begin
      instr_valid <= 1'b1;
      instr       <= word;
    end
  end
endmodule
`default_nettype wire

// *** bench/ogm_unit_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module ogm_unit_chk
  import ogm_pkg::*;
#(
  parameter int WIDTH = 12
)
(
  input wire logic             clk,
  input wire logic             reset,
  input wire logic             instr_valid,
  input wire logic [WIDTH-1:0] instr,
  input wire logic             busy_q,
  input wire logic             done_q,
  input wire logic [4:0]       states_q,
  input wire logic             grp2_valid_q,
  input wire logic             grp3_valid_q,
  input wire logic [WIDTH-1:0] route_word_q,
  input wire logic             bad_rot_q,
  input wire logic [WIDTH-1:0] accumulator_reg_q,
  input wire logic             carry_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Words count only when taken while idle
  wire logic tk = instr_valid && !busy_q;
  wire logic op = tk && instr[11:9] == 3'h7;
  wire logic g1 = op && !instr[8];
  property p_g1_seq;
    g1 |=> busy_q [*4] ##1 (done_q && !busy_q);
  endproperty
  a_g1_seq: assert property (p_g1_seq) else $error("g1 timing");
  property p_grp2;
    op && instr[8] && !instr[0] |=> grp2_valid_q && !grp3_valid_q;
  endproperty
  a_grp2: assert property (p_grp2) else $error("group 2 route");
  property p_grp3;
    op && instr[8] && instr[0] |=> grp3_valid_q && !grp2_valid_q;
  endproperty
  a_grp3: assert property (p_grp3) else $error("group 3 route");
  property p_other;
    tk && instr[11:9] != 3'h7 |=> !grp2_valid_q && !grp3_valid_q && !busy_q;
  endproperty
  a_other: assert property (p_other) else $error("non operate");
  property p_long;
    g1 && instr[3:1] inside {[3'h1:3'h5]} |-> ##5 states_q == 5'h0F;
  endproperty
  a_long: assert property (p_long) else $error("long cost");
  property p_bad;
    g1 && instr[3] && instr[2] |-> ##5 bad_rot_q && states_q == 5'h0A;
  endproperty
  a_bad: assert property (p_bad) else $error("bad selector");
  property p_idle_op;
    g1 && instr[7:0] == 8'h00 |-> ##5 carry_q == $past(carry_q, 5)
      && accumulator_reg_q == $past(accumulator_reg_q, 5);
  endproperty
  a_idle_op: assert property (p_idle_op) else $error("idle op");
  property p_clear;
    g1 && (instr[7:0] & 8'hAF) == 8'h80 |-> ##5 accumulator_reg_q == 12'h000;
  endproperty
  a_clear: assert property (p_clear) else $error("clear acc");
  c_rot: cover property (g1 && instr[3:1] == 3'h2);
  c_grp2: cover property (grp2_valid_q);
  c_bad: cover property (bad_rot_q);
endmodule
bind ogm_unit ogm_unit_chk #(.WIDTH(WIDTH)) chk_u (
  .clk(clk), .reset(reset), .instr_valid(instr_valid), .instr(instr),
  .busy_q(busy_q), .done_q(done_q), .states_q(states_q),
  .grp2_valid_q(grp2_valid_q), .grp3_valid_q(grp3_valid_q),
  .route_word_q(route_word_q), .bad_rot_q(bad_rot_q),
  .accumulator_reg_q(accumulator_reg_q), .carry_q(carry_q)
);
`default_nettype wire

// *** bench/ogm_unit_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  bad_count++; $display("wrong value %s exp %0h got %0h", n, e, a); end end
module ogm_unit_bench
  import ogm_pkg::*;
;
  logic        clk = 1'b0, reset = 1'b1, send = 1'b0;
  logic [11:0] word = 12'h000;
  logic        instr_valid, busy_q, done_q, carry_q, bad_rot_q, g2_q, g3_q;
  logic [11:0] instr, route_word_q, accumulator_reg_q;
  logic [4:0]  states_q;
  logic [12:0] exp_q = 13'h0000; // Expected carry and accumulator
  int          bad_count = 0, samples_checked = 0;
  always #2.5 clk = ~clk;
  ogm_fetch_model fetch_u (.clk(clk), .reset(reset), .send(send),
    .word(word), .busy_q(busy_q), .instr_valid(instr_valid), .instr(instr));
  ogm_unit #(.WIDTH(12)) dut_u (.clk(clk), .reset(reset),
    .instr_valid(instr_valid), .instr(instr), .busy_q(busy_q),
    .done_q(done_q), .states_q(states_q), .grp2_valid_q(g2_q),
    .grp3_valid_q(g3_q), .route_word_q(route_word_q), .bad_rot_q(bad_rot_q),
    .accumulator_reg_q(accumulator_reg_q), .carry_q(carry_q));
  // Reference: phases in order, each on the previous phase's result
  function automatic logic [12:0] ref_g1(logic [12:0] v, logic [11:0] w);
    logic [12:0] r;
    r = v;
    if (w[7]) r[11:0] = 12'h000;
    if (w[6]) r[12] = 1'b0;
    if (w[5]) r[11:0] = ~r[11:0];
    if (w[4]) r[12] = ~r[12];
    if (w[0]) r = {r[12] ^ (&r[11:0]), r[11:0] + 12'h001};
    case (w[3:1])
      3'h1: r[11:0] = {r[5:0], r[11:6]};
      3'h2: r = {r[11:0], r[12]};
      3'h3: r = {r[10:0], r[12:11]};
      3'h4: r = {r[0], r[12:1]};
      3'h5: r = {r[1:0], r[12:2]};
      default: r = r;
    endcase
    return r;
  endfunction
  task automatic send_word(input logic [11:0] w);
    @(posedge clk);
    send <= 1'b1;
    word <= w;
    @(posedge clk);
    send <= 1'b0;
  endtask
  // Sample on the falling edge, after the unit's updates have landed
  task automatic wait_evt(output logic [2:0] seen, output int n);
    seen = 3'h0;
    for (n = 0; n < 12 && seen == 3'h0; n++) begin
      @(negedge clk);
      seen = {g3_q, g2_q, done_q};
    end
  endtask
  task automatic t_group1();
    logic [11:0] ws [20] = '{12'hE00, 12'hE20, 12'hE01, 12'hE10, 12'hE50,
      12'hE84, 12'hED5, 12'hE04, 12'hE06, 12'hE08, 12'hE0A, 12'hE02,
      12'hE0C, 12'hE0E, 12'hEE8, 12'hEEA, 12'hEE6, 12'hE30, 12'hE80,
      12'hE21};
    logic [2:0]  seen;
    int          n;
    foreach (ws[i]) begin
      exp_q = ref_g1(exp_q, ws[i]);
      send_word(ws[i]);
      wait_evt(seen, n);
      `CHK("done", 3'h1, seen)
      // Taken two edges after send, done four edges later
      `CHK("cycles", 6, n)
      `CHK("busy", 1'b0, busy_q)
      `CHK("acc", exp_q[11:0], accumulator_reg_q)
      `CHK("carry", exp_q[12], carry_q)
      `CHK("states", (ws[i][3:1] inside {[3'h1:3'h5]}) ? 5'h0F : 5'h0A,
        states_q)
      `CHK("bad", ws[i][3] & ws[i][2], bad_rot_q)
    end
    $display("t_group1 end");
  endtask
  task automatic t_other();
    logic [11:0] ws [3] = '{12'hF48, 12'hF01, 12'h5A3};
    logic [2:0]  ex [3] = '{3'h2, 3'h4, 3'h0};
    logic [2:0]  seen;
    int          n;
    foreach (ws[i]) begin
      send_word(ws[i]);
      wait_evt(seen, n);
      `CHK("class", ex[i], seen)
      `CHK("route", ws[i], route_word_q)
      `CHK("acc kept", exp_q[11:0], accumulator_reg_q)
    end
    $display("t_other end");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Whole run is under two hundred cycles; the limit leaves ample margin
  initial begin
    #20000;
    bad_count++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    `CHK("acc reset", 12'h000, accumulator_reg_q)
    t_group1();
    t_other();
    finish_test();
  end
endmodule
`default_nettype wire
